// ---- bit_unit_pkg.sv ----
package bit_unit_pkg;

    // bus geometry
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam int          WIN_LSB      = 7;
    localparam int          IDX_LSB      = 2;
    localparam int          IDX_W        = 5;

    // register map, byte addresses
    localparam logic [11:0] CMD_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] SP_OFFSET    = 12'h008;
    localparam logic [11:0] GPR_BASE     = 12'h100;
    localparam logic [11:0] IO_BASE      = 12'h200;
    localparam logic [11:0] STACK_BASE   = 12'h300;

    // command word fields
    localparam int          OPC_LSB      = 0;
    localparam int          OPC_W        = 5;
    localparam int          RD_LSB       = 5;
    localparam int          SRC_LSB      = 10;
    localparam int          BIT_LSB      = 15;
    localparam int          BIT_W        = 3;
    localparam int          IO_LSB       = 18;
    localparam int          CMD_W        = 23;

    // status register flag positions
    localparam int          FLAG_C       = 0;
    localparam int          FLAG_Z       = 1;
    localparam int          FLAG_N       = 2;
    localparam int          FLAG_V       = 3;
    localparam int          FLAG_S       = 4;
    localparam int          FLAG_H       = 5;
    localparam int          FLAG_T       = 6;
    localparam int          FLAG_I       = 7;

    // reset values
    localparam logic [7:0]  STATUS_REGISTER_RESET   = 8'h00;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
    localparam logic [22:0] CMD_RESET    = 23'h00_0000;

    // operation codes
    typedef enum logic [4:0] {
        OP_NOP          = 5'h00,
        OP_PUSH         = 5'h01,
        OP_POP          = 5'h02,
        OP_IO_SET       = 5'h03,
        OP_IO_CLR       = 5'h04,
        OP_SHL          = 5'h05,
        OP_SHR          = 5'h06,
        OP_ROT_LEFT     = 5'h07,
        OP_ROT_RIGHT    = 5'h08,
        OP_ASHR         = 5'h09,
        OP_NIBBLE_SWAP  = 5'h0A,
        OP_FLAG_SET     = 5'h0B,
        OP_FLAG_CLR     = 5'h0C,
        OP_STORE_T      = 5'h0D,
        OP_LOAD_T       = 5'h0E,
        OP_CARRY_SET    = 5'h0F,
        OP_CARRY_CLR    = 5'h10,
        OP_NEG_SET      = 5'h11,
        OP_NEG_CLR      = 5'h12,
        OP_ZERO_SET     = 5'h13,
        OP_ZERO_CLR     = 5'h14,
        OP_INT_EN       = 5'h15,
        OP_INT_DIS      = 5'h16,
        OP_SIGN_SET     = 5'h17,
        OP_SIGN_CLR     = 5'h18,
        OP_OVF_SET      = 5'h19,
        OP_OVF_CLR      = 5'h1A
    } op_t;

endpackage

// ---- bit_flag_unit.sv ----
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - push stores source register on stack; pop loads top byte into destination
// - io bit set forces bit b of io register to one, others kept
// - logical shift left moves bits upward, zero enters bit 0
// - logical shift right moves bits downward, zero enters bit 7
// - rotate left: old carry into bit 0, old bit 7 into carry
// - rotate right: old carry into bit 7, old bit 0 into carry
// - arithmetic shift right copies bits 1..7 down, bit 7 kept
// - nibble swap exchanges low and high four bits at once
// - flag set or clear forces the status flag selected by s
// - store to transfer bit copies source bit b into T
// - load from transfer bit copies T into destination bit b only
// - dedicated ops set and clear the carry flag
// - dedicated ops set and clear the negative flag
// - dedicated ops set and clear the zero flag
// - interrupt enable sets I, interrupt disable clears I
// - dedicated ops set and clear the sign flag
// - dedicated ops set and clear the overflow flag
module bit_flag_unit #(
    parameter int STACK_DEPTH = 16
) (
    // clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    // avalon-mm slave
    input  wire logic [bit_unit_pkg::ADDR_W-1:0]   address,
    input  wire logic                              read,
    input  wire logic                              write,
    input  wire logic [bit_unit_pkg::DATA_W-1:0]   writedata,
    input  wire logic [3:0]                        byteenable,
    output logic      [bit_unit_pkg::DATA_W-1:0]   readdata,
    output logic                                   waitrequest,
    // core status
    output logic      [7:0]                        status_flags
);

    localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    function automatic logic [7:0] put_bit(input logic [7:0] val,
                                           input logic [2:0] idx,
                                           input logic       b);
        put_bit = b ? (val | bit_mask(idx)) : (val & ~bit_mask(idx));
    endfunction

    function automatic logic in_window(input logic [11:0] addr,
                                       input logic [11:0] base);
        in_window = (addr[11:bit_unit_pkg::WIN_LSB] == base[11:bit_unit_pkg::WIN_LSB]);
    endfunction

    logic [7:0]                         gpr       [32];
    logic [7:0]                         io_regs   [32];
    logic [7:0]                         stack_mem [STACK_DEPTH];
    logic [SP_W-1:0]                    sp;
    logic [bit_unit_pkg::CMD_W-1:0]     cmd;

    logic                               wr_go;
    logic                               rd_go;
    logic [bit_unit_pkg::IDX_W-1:0]     win_idx;
    logic                               sel_cmd;
    logic                               sel_status;
    logic                               sel_sp;
    logic                               sel_gpr;
    logic                               sel_io;
    logic                               sel_stack;

    logic [bit_unit_pkg::CMD_W-1:0]     next_cmd;
    bit_unit_pkg::op_t                  op;
    logic [4:0]                         rd_idx;
    logic [4:0]                         src_idx;
    logic [2:0]                         bit_idx;
    logic [4:0]                         io_idx;
    logic [7:0]                         rd_val;
    logic [7:0]                         src_val;
    logic [SP_W-1:0]                    sp_up;
    logic [SP_W-1:0]                    sp_down;

    logic                               do_exec;
    logic                               rd_we;
    logic [7:0]                         next_rd;
    logic                               io_we;
    logic [7:0]                         next_io;
    logic                               do_push;
    logic                               do_pop;
    logic [7:0]                         next_flags;
    logic [bit_unit_pkg::DATA_W-1:0]    next_readdata;

    // a request is served at the edge where waitrequest is sampled low
    assign wr_go     = write && !waitrequest;
    assign rd_go     = read && !waitrequest;
    assign win_idx   = address[bit_unit_pkg::IDX_LSB +: bit_unit_pkg::IDX_W];
    assign sel_cmd   = (address == bit_unit_pkg::CMD_OFFSET);
    assign sel_status = (address == bit_unit_pkg::STATUS_OFFSET);
    assign sel_sp    = (address == bit_unit_pkg::SP_OFFSET);
    assign sel_gpr   = in_window(address, bit_unit_pkg::GPR_BASE);
    assign sel_io    = in_window(address, bit_unit_pkg::IO_BASE);
    assign sel_stack = in_window(address, bit_unit_pkg::STACK_BASE)
                       && (32'(win_idx) < STACK_DEPTH);

    // byte lanes merge into the command word before it is decoded
    always_comb begin
        next_cmd = cmd;
        if (byteenable[0]) begin
            next_cmd[7:0] = writedata[7:0];
        end
        if (byteenable[1]) begin
            next_cmd[15:8] = writedata[15:8];
        end
        if (byteenable[2]) begin
            next_cmd[22:16] = writedata[22:16];
        end
    end

    assign do_exec = wr_go && sel_cmd;
    assign op      = bit_unit_pkg::op_t'(next_cmd[bit_unit_pkg::OPC_LSB +: bit_unit_pkg::OPC_W]);
    assign rd_idx  = next_cmd[bit_unit_pkg::RD_LSB +: 5];
    assign src_idx = next_cmd[bit_unit_pkg::SRC_LSB +: 5];
    assign bit_idx = next_cmd[bit_unit_pkg::BIT_LSB +: bit_unit_pkg::BIT_W];
    assign io_idx  = next_cmd[bit_unit_pkg::IO_LSB +: 5];
    assign rd_val  = gpr[rd_idx];
    assign src_val = gpr[src_idx];
    assign sp_up   = sp + 1'b1;
    assign sp_down = sp - 1'b1;

    // one operation per command write; unknown codes change nothing
    always_comb begin
        rd_we      = 1'b0;
        next_rd    = rd_val;
        io_we      = 1'b0;
        next_io    = io_regs[io_idx];
        do_push    = 1'b0;
        do_pop     = 1'b0;
        next_flags = status_flags;
        case (op)
            bit_unit_pkg::OP_PUSH: begin
                do_push = 1'b1;
            end
            bit_unit_pkg::OP_POP: begin
                do_pop  = 1'b1;
                rd_we   = 1'b1;
                next_rd = stack_mem[sp_up];
            end
            bit_unit_pkg::OP_IO_SET: begin
                io_we   = 1'b1;
                next_io = io_regs[io_idx] | bit_mask(bit_idx);
            end
            bit_unit_pkg::OP_IO_CLR: begin
                io_we   = 1'b1;
                next_io = io_regs[io_idx] & ~bit_mask(bit_idx);
            end
            bit_unit_pkg::OP_SHL: begin
                rd_we   = 1'b1;
                next_rd = {rd_val[6:0], 1'b0};
            end
            bit_unit_pkg::OP_SHR: begin
                rd_we   = 1'b1;
                next_rd = {1'b0, rd_val[7:1]};
            end
            bit_unit_pkg::OP_ROT_LEFT: begin
                rd_we   = 1'b1;
                next_rd = {rd_val[6:0], status_flags[bit_unit_pkg::FLAG_C]};
                next_flags[bit_unit_pkg::FLAG_C] = rd_val[7];
            end
            bit_unit_pkg::OP_ROT_RIGHT: begin
                rd_we   = 1'b1;
                next_rd = {status_flags[bit_unit_pkg::FLAG_C], rd_val[7:1]};
                next_flags[bit_unit_pkg::FLAG_C] = rd_val[0];
            end
            bit_unit_pkg::OP_ASHR: begin
                rd_we   = 1'b1;
                next_rd = {rd_val[7], rd_val[7:1]};
            end
            bit_unit_pkg::OP_NIBBLE_SWAP: begin
                rd_we   = 1'b1;
                next_rd = {rd_val[3:0], rd_val[7:4]};
            end
            bit_unit_pkg::OP_FLAG_SET: begin
                next_flags = put_bit(status_flags, bit_idx, 1'b1);
            end
            bit_unit_pkg::OP_FLAG_CLR: begin
                next_flags = put_bit(status_flags, bit_idx, 1'b0);
            end
            bit_unit_pkg::OP_STORE_T: begin
                next_flags[bit_unit_pkg::FLAG_T] = src_val[bit_idx];
            end
            bit_unit_pkg::OP_LOAD_T: begin
                rd_we   = 1'b1;
                next_rd = put_bit(rd_val, bit_idx,
                                  status_flags[bit_unit_pkg::FLAG_T]);
            end
            bit_unit_pkg::OP_CARRY_SET: begin
                next_flags[bit_unit_pkg::FLAG_C] = 1'b1;
            end
            bit_unit_pkg::OP_CARRY_CLR: begin
                next_flags[bit_unit_pkg::FLAG_C] = 1'b0;
            end
            bit_unit_pkg::OP_NEG_SET: begin
                next_flags[bit_unit_pkg::FLAG_N] = 1'b1;
            end
            bit_unit_pkg::OP_NEG_CLR: begin
                next_flags[bit_unit_pkg::FLAG_N] = 1'b0;
            end
            bit_unit_pkg::OP_ZERO_SET: begin
                next_flags[bit_unit_pkg::FLAG_Z] = 1'b1;
            end
            bit_unit_pkg::OP_ZERO_CLR: begin
                next_flags[bit_unit_pkg::FLAG_Z] = 1'b0;
            end
            bit_unit_pkg::OP_INT_EN: begin
                next_flags[bit_unit_pkg::FLAG_I] = 1'b1;
            end
            bit_unit_pkg::OP_INT_DIS: begin
                next_flags[bit_unit_pkg::FLAG_I] = 1'b0;
            end
            bit_unit_pkg::OP_SIGN_SET: begin
                next_flags[bit_unit_pkg::FLAG_S] = 1'b1;
            end
            bit_unit_pkg::OP_SIGN_CLR: begin
                next_flags[bit_unit_pkg::FLAG_S] = 1'b0;
            end
            bit_unit_pkg::OP_OVF_SET: begin
                next_flags[bit_unit_pkg::FLAG_V] = 1'b1;
            end
            bit_unit_pkg::OP_OVF_CLR: begin
                next_flags[bit_unit_pkg::FLAG_V] = 1'b0;
            end
            default: begin
            end
        endcase
    end

    // one wait cycle per access, so read data is settled before it is taken
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        next_readdata = bit_unit_pkg::WORD_ZERO;
        if (sel_cmd) begin
            next_readdata = 32'(cmd);
        end else if (sel_status) begin
            next_readdata = 32'(status_flags);
        end else if (sel_sp) begin
            next_readdata = 32'(sp);
        end else if (sel_gpr) begin
            next_readdata = 32'(gpr[win_idx]);
        end else if (sel_io) begin
            next_readdata = 32'(io_regs[win_idx]);
        end else if (sel_stack) begin
            next_readdata = 32'(stack_mem[win_idx[SP_W-1:0]]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readdata <= bit_unit_pkg::WORD_ZERO;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd <= bit_unit_pkg::CMD_RESET;
        end else if (do_exec) begin
            cmd <= next_cmd;
        end
    end

    // software writes the whole status byte; an operation touches only its flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_flags <= bit_unit_pkg::STATUS_REGISTER_RESET;
        end else if (wr_go && sel_status && byteenable[0]) begin
            status_flags <= writedata[7:0];
        end else if (do_exec) begin
            status_flags <= next_flags;
        end
    end

    // register file: bus access or operation result
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= bit_unit_pkg::BYTE_RESET;
            end
        end else if (wr_go && sel_gpr && byteenable[0]) begin
            gpr[win_idx] <= writedata[7:0];
        end else if (do_exec && rd_we) begin
            gpr[rd_idx] <= next_rd;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                io_regs[i] <= bit_unit_pkg::BYTE_RESET;
            end
        end else if (wr_go && sel_io && byteenable[0]) begin
            io_regs[win_idx] <= writedata[7:0];
        end else if (do_exec && io_we) begin
            io_regs[io_idx] <= next_io;
        end
    end

    // stack grows downward; the pointer wraps, no overflow guard
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= bit_unit_pkg::BYTE_RESET;
            end
        end else if (wr_go && sel_stack && byteenable[0]) begin
            stack_mem[win_idx[SP_W-1:0]] <= writedata[7:0];
        end else if (do_exec && do_push) begin
            stack_mem[sp] <= src_val;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sp <= SP_W'(STACK_DEPTH - 1);
        end else if (wr_go && sel_sp && byteenable[0]) begin
            sp <= writedata[SP_W-1:0];
        end else if (do_exec && do_push) begin
            sp <= sp_down;
        end else if (do_exec && do_pop) begin
            sp <= sp_up;
        end
    end

endmodule

// ---- flag_unit_chk_sva.sv ----
`timescale 1ns/1ns
module flag_unit_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // bus and status
    input wire logic [11:0] address,
    input wire logic        write,
    input wire logic        read,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic        waitrequest,
    input wire logic [7:0]  status_flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic       fire;
    logic [4:0] op;

    // a command only counts when all three command lanes are written
    assign fire = write && !waitrequest && address == bit_unit_pkg::CMD_OFFSET
                  && byteenable[2:0] == 3'h7;
    assign op   = writedata[4:0];

    a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_request_answered: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered next cycle");
    a_flag_set_sel: assert property (
        fire && op == 5'h0B |=> status_flags[$past(writedata[17:15])])
        else $error("selected flag not set");
    a_flag_clear_sel: assert property (
        fire && op == 5'h0C |=> !status_flags[$past(writedata[17:15])])
        else $error("selected flag not cleared");
    // odd code of each dedicated pair sets, even code clears
    a_carry_pair: assert property (
        fire && (op == 5'h0F || op == 5'h10) |=> status_flags[0] == $past(writedata[0]))
        else $error("carry op wrong");
    a_neg_pair: assert property (
        fire && (op == 5'h11 || op == 5'h12) |=> status_flags[2] == $past(writedata[0]))
        else $error("negative op wrong");
    a_zero_pair: assert property (
        fire && (op == 5'h13 || op == 5'h14) |=> status_flags[1] == $past(writedata[0]))
        else $error("zero op wrong");
    a_int_pair: assert property (
        fire && (op == 5'h15 || op == 5'h16) |=> status_flags[7] == $past(writedata[0]))
        else $error("interrupt op wrong");
    a_sign_pair: assert property (
        fire && (op == 5'h17 || op == 5'h18) |=> status_flags[4] == $past(writedata[0]))
        else $error("sign op wrong");
    a_ovf_pair: assert property (
        fire && (op == 5'h19 || op == 5'h1A) |=> status_flags[3] == $past(writedata[0]))
        else $error("overflow op wrong");
    a_shift_keeps_flags: assert property (
        fire && op inside {[5'h01:5'h06], 5'h09, 5'h0A} |=> $stable(status_flags))
        else $error("flags moved by data op");
endmodule

bind bit_flag_unit flag_unit_chk chk (.ref_clk(ref_clk), .rst(rst), .address(address),
    .write(write), .read(read), .writedata(writedata), .byteenable(byteenable),
    .waitrequest(waitrequest), .status_flags(status_flags));

// ---- tb_bit_flag_unit.sv ----
`timescale 1ns/1ns
module tb_bit_flag_unit;
    logic        ref_clk;
    logic        rst;
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [7:0]  status_flags;
    logic [31:0] q;
    int          miscompares;
    int          tests_run;

    bit_flag_unit #(.STACK_DEPTH(16)) dut (.ref_clk(ref_clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .status_flags(status_flags));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // bounded wait: a slave that never answers ends the run
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        read      <= !wr;
        write     <= wr;
        address   <= a;
        writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            miscompares++;
            give_verdict;
        end
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    function automatic logic [11:0] at(input logic [11:0] base, input int n);
        return base + 12'(4 * n);
    endfunction

    task wr(input logic [11:0] a, input logic [7:0] v);
        bus(1'b1, a, {24'h00_0000, v});
    endtask

    task rd(input logic [11:0] a, input logic [7:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, {24'h00_0000, exp});
    endtask

    task cmd(input logic [4:0] op, input logic [4:0] d, input logic [4:0] r,
             input logic [2:0] b, input logic [4:0] p);
        bus(1'b1, bit_unit_pkg::CMD_OFFSET, {9'h000, p, b, r, d, op});
        @(negedge ref_clk);
    endtask

    task t_reset;
        chk(status_flags, 8'h00);
        rd(bit_unit_pkg::STATUS_OFFSET, 8'h00);
        wr(12'h0F0, 8'h5A);
        rd(12'h0F0, 8'h00);
    endtask

    // two pushes then two pops prove last-in first-out order
    task t_stack;
        wr(at(bit_unit_pkg::GPR_BASE, 5), 8'hA7);
        wr(at(bit_unit_pkg::GPR_BASE, 4), 8'h3C);
        cmd(5'h01, 5'h00, 5'h05, 3'h0, 5'h00);
        cmd(5'h01, 5'h00, 5'h04, 3'h0, 5'h00);
        cmd(5'h02, 5'h06, 5'h00, 3'h0, 5'h00);
        cmd(5'h02, 5'h07, 5'h00, 3'h0, 5'h00);
        rd(at(bit_unit_pkg::GPR_BASE, 6), 8'h3C);
        rd(at(bit_unit_pkg::GPR_BASE, 7), 8'hA7);
        rd(bit_unit_pkg::SP_OFFSET, 8'h0F);
        rd(at(bit_unit_pkg::STACK_BASE, 14), 8'h3C);
        rd(bit_unit_pkg::CMD_OFFSET, 8'hE2);
        cmd(5'h1F, 5'h07, 5'h07, 3'h0, 5'h00);
        rd(at(bit_unit_pkg::GPR_BASE, 7), 8'hA7);
    endtask

    task t_io;
        wr(at(bit_unit_pkg::IO_BASE, 2), 8'h50);
        cmd(5'h03, 5'h00, 5'h00, 3'h1, 5'h02);
        rd(at(bit_unit_pkg::IO_BASE, 2), 8'h52);
        cmd(5'h04, 5'h00, 5'h00, 3'h4, 5'h02);
        rd(at(bit_unit_pkg::IO_BASE, 2), 8'h42);
        cmd(5'h03, 5'h00, 5'h00, 3'h7, 5'h1F);
        rd(at(bit_unit_pkg::IO_BASE, 31), 8'h80);
    endtask

    task one_op(input logic [4:0] op, input logic [7:0] v, input logic [7:0] exp);
        wr(at(bit_unit_pkg::GPR_BASE, 3), v);
        cmd(op, 5'h03, 5'h00, 3'h0, 5'h00);
        rd(at(bit_unit_pkg::GPR_BASE, 3), exp);
    endtask

    task t_shifts;
        one_op(5'h05, 8'hB5, 8'h6A);
        one_op(5'h06, 8'hB5, 8'h5A);
        one_op(5'h09, 8'hB5, 8'hDA);
        one_op(5'h0A, 8'hB5, 8'h5B);
        wr(bit_unit_pkg::STATUS_OFFSET, 8'h01);
        one_op(5'h07, 8'h35, 8'h6B);
        chk(status_flags, 8'h00);
        one_op(5'h08, 8'h35, 8'h1A);
        chk(status_flags, 8'h01);
        one_op(5'h08, 8'h00, 8'h80);
        chk(status_flags, 8'h00);
    endtask

    task t_flags;
        logic [7:0] e;
        e = 8'h00;
        wr(bit_unit_pkg::STATUS_OFFSET, e);
        for (int s = 0; s < 8; s++) begin
            cmd(5'h0B, 5'h00, 5'h00, 3'(s), 5'h00);
            e[s] = 1'b1;
            chk(status_flags, e);
        end
        for (int s = 0; s < 8; s++) begin
            cmd(5'h0C, 5'h00, 5'h00, 3'(s), 5'h00);
            e[s] = 1'b0;
            chk(status_flags, e);
        end
    endtask

    task t_tbit;
        wr(at(bit_unit_pkg::GPR_BASE, 7), 8'h08);
        wr(at(bit_unit_pkg::GPR_BASE, 8), 8'h00);
        cmd(5'h0D, 5'h00, 5'h07, 3'h3, 5'h00);
        chk(status_flags, 8'h40);
        cmd(5'h0E, 5'h08, 5'h00, 3'h6, 5'h00);
        rd(at(bit_unit_pkg::GPR_BASE, 8), 8'h40);
        wr(at(bit_unit_pkg::GPR_BASE, 9), 8'hFF);
        cmd(5'h0D, 5'h00, 5'h07, 3'h0, 5'h00);
        chk(status_flags, 8'h00);
        cmd(5'h0E, 5'h09, 5'h00, 3'h7, 5'h00);
        rd(at(bit_unit_pkg::GPR_BASE, 9), 8'h7F);
    endtask

    task t_dedicated;
        int pos [6];
        pos = '{0, 2, 1, 7, 4, 3};
        for (int k = 0; k < 6; k++) begin
            wr(bit_unit_pkg::STATUS_OFFSET, 8'h00);
            cmd(5'(15 + 2 * k), 5'h00, 5'h00, 3'h0, 5'h00);
            chk(status_flags, 8'h01 << pos[k]);
            wr(bit_unit_pkg::STATUS_OFFSET, 8'hFF);
            cmd(5'(16 + 2 * k), 5'h00, 5'h00, 3'h0, 5'h00);
            chk(status_flags, 8'(~(8'h01 << pos[k])));
        end
    endtask

    initial begin
        rst         = 1'b1;
        address     = 12'h000;
        read        = 1'b0;
        write       = 1'b0;
        writedata   = 32'h0000_0000;
        byteenable  = 4'hF;
        miscompares = 0;
        tests_run   = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_stack;
        t_io;
        t_shifts;
        t_flags;
        t_tbit;
        t_dedicated;
        give_verdict;
    end
endmodule
